// File: dv/pcg_periph_model.sv
// Peripheral bank model fed by the gated clocks
`timescale 1ns/10ps
module pcg_periph_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Gating from the block
   input wire logic [15:0] periphClockRun,
   input wire logic [15:0] periphStopped,
   input wire logic [15:0] periphAccessGrant,
   // Requests commanded by the bench
   input wire logic [15:0] reqIn,
   output logic [15:0] periphAccessReq,
   // Observed state
   output logic [15:0] hits,
   output logic violation
);
   assign periphAccessReq = reqIn;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hits <= 16'h0000;
         violation <= 1'b0;
      end else begin
         hits <= (hits | periphAccessGrant) & periphClockRun;
         violation <= violation | (|(periphAccessGrant & periphStopped));
      end
   end
endmodule // pcg_periph_model

// File: dv/tb_top.sv
// Self-checking bench for the peripheral clock control block
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end
module tb_top;
   import pcg_pkg::*;
   logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, pinSel = 1, pllActive = 1, stopMode = 0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [4:0] srcs = 5'h00;
   logic [3:0] pwmOut = 4'h0, portA;
   logic [15:0] keep = 16'h0, reqIn = 16'h0, run, stopped, req, grant, hits;
   logic hready, hresp, cop, copEn, tFast, pFast, wFast, violation;
   int err_count = 0, n_checks = 0, cycles = 0;
   always #5 ref_clk = ~ref_clk;
   pcg_clock_control DUT (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .sysClock(srcs[0]),
      .periphClock(srcs[1]), .sysClock2x(srcs[2]), .sysClock3x(srcs[3]),
      .relaxOscClock(srcs[4]), .pllActive(pllActive), .pwmOut(pwmOut),
      .portAPeriphOut(portA), .portBPinSelectClockOut(pinSel), .clockOutPin(cop),
      .clockOutPinEnable(copEn), .timerFastClock(tFast), .pulseWidthFastClock(pFast),
      .twoWireFastClock(wFast), .stopMode(stopMode), .stopKeepClock(keep),
      .periphClockRun(run), .periphStopped(stopped), .periphAccessReq(req),
      .periphAccessGrant(grant));
   pcg_periph_model PM (.ref_clk(ref_clk), .rst(rst), .periphClockRun(run),
      .periphStopped(stopped), .periphAccessGrant(grant), .reqIn(reqIn),
      .periphAccessReq(req), .hits(hits), .violation(violation));
////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         conclude();
      end
   end
   task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= 32'(idx) << ADDR_LSB;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
      #1;
   endtask
   task automatic wr(input logic [5:0] i, input logic [15:0] d);
      bus(1'b1, i, 32'(d));
   endtask
   task automatic rdchk(input logic [5:0] i, input logic [15:0] e);
      bus(1'b0, i, 32'h0);
      `CHK(rd, 32'(e))
      `CHK(hresp, HRESP_OKAY)
   endtask
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic drive(input logic [4:0] s, input logic [3:0] p);
      @(posedge ref_clk);
      srcs <= s;
      pwmOut <= p;
      #1;
   endtask
////////////////////////////////////////
   task automatic t_reset();
      rdchk(IDX_CLOCK_OUTPUT_SELECT, 16'h0020);
      rdchk(IDX_PERIPHERAL_CLOCK_RATE, 16'h0000);
      rdchk(IDX_PERIPHERAL_CLOCK_ENABLE_LOW, 16'h0000);
      rdchk(6'h0d, 16'h0000);
      drive(5'h1f, 4'ha);
      `CHK(portA, 4'ha)
      `CHK(copEn, 1'b0)
      `CHK(stopped, 16'hf455)
      `CHK({tFast, pFast, wFast}, 3'h0)
      $display("test reset done");
   endtask
   task automatic t_port_a();
      int src[4] = '{3, 2, 0, 4};
      for (int n = 0; n < 4; n++) begin
         wr(IDX_CLOCK_OUTPUT_SELECT, 16'h0020 | (16'h0040 << n));
         drive(5'h01 << src[n], 4'h0);
         `CHK(portA, 4'h1 << n)
         drive(~(5'h01 << src[n]), 4'hf);
         `CHK(portA, ~(4'h1 << n))
      end
      $display("test port_a done");
   endtask
   task automatic t_clock_out();
      int src[3] = '{0, 1, 3};
      for (int c = 0; c < 3; c++) begin
         wr(IDX_CLOCK_OUTPUT_SELECT, 16'(c));
         drive(5'h01 << src[c], 4'h0);
         `CHK({copEn, cop}, 2'h3)
         drive(~(5'h01 << src[c]), 4'h0);
         `CHK({copEn, cop}, 2'h2)
      end
      drive(5'h08, 4'h0);
      @(posedge ref_clk);
      pllActive <= 1'b0;
      #1;
      `CHK(cop, 1'b0)
      @(posedge ref_clk);
      pllActive <= 1'b1;
      wr(IDX_CLOCK_OUTPUT_SELECT, 16'h0004);
      drive(5'h1f, 4'h0);
      `CHK(cop, 1'b0)
      wr(IDX_CLOCK_OUTPUT_SELECT, 16'h0020);
      `CHK(copEn, 1'b0)
      wr(IDX_CLOCK_OUTPUT_SELECT, 16'h0000);
      @(posedge ref_clk);
      pinSel <= 1'b0;
      #1;
      `CHK(copEn, 1'b0)
      @(posedge ref_clk);
      pinSel <= 1'b1;
      $display("test clock_out done");
   endtask
   task automatic t_reserved();
      logic [5:0] idx[3] = '{IDX_CLOCK_OUTPUT_SELECT, IDX_PERIPHERAL_CLOCK_RATE,
         IDX_PERIPHERAL_CLOCK_ENABLE_LOW};
      logic [15:0] msk[3] = '{16'h03ff, 16'h7000, 16'hf455};
      for (int i = 0; i < 3; i++) begin
         wr(idx[i], msk[i]);
         rdchk(idx[i], msk[i]);
      end
      $display("test reserved done");
   endtask
   task automatic t_rate();
      wr(IDX_PERIPHERAL_CLOCK_ENABLE_LOW, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         wr(IDX_PERIPHERAL_CLOCK_RATE, 16'h1000 << i);
         tick();
         `CHK({tFast, pFast, wFast}, 3'h1 << i)
      end
      @(posedge ref_clk);
      pllActive <= 1'b0;
      tick();
      `CHK({tFast, pFast, wFast}, 3'h0)
      @(posedge ref_clk);
      pllActive <= 1'b1;
      $display("test rate done");
   endtask
   task automatic t_gate();
      for (int b = 0; b < 16; b++) begin
         wr(IDX_PERIPHERAL_CLOCK_ENABLE_LOW, (16'h0001 << b) & 16'hf455);
         tick();
         `CHK(run, (16'h0001 << b) & 16'hf455)
      end
      wr(IDX_PERIPHERAL_CLOCK_ENABLE_LOW, 16'hf455);
      tick();
      `CHK(stopped, 16'h0000)
      @(posedge ref_clk);
      stopMode <= 1'b1;
      keep <= 16'h0011;
      tick();
      `CHK(run, 16'h0011)
      `CHK(stopped, 16'hf444)
      wr(IDX_PERIPHERAL_CLOCK_ENABLE_LOW, 16'h0010);
      tick();
      `CHK(run, 16'h0010)
      @(posedge ref_clk);
      stopMode <= 1'b0;
      reqIn <= 16'hffff;
      #1;
      `CHK(grant, 16'h0010)
      tick();
      `CHK(hits, 16'h0010)
      `CHK(violation, 1'b0)
      wr(IDX_PERIPHERAL_CLOCK_ENABLE_LOW, 16'h0000);
      tick();
      tick();
      `CHK(hits, 16'h0000)
      @(posedge ref_clk);
      reqIn <= 16'h0000;
      $display("test gate done");
   endtask
   task automatic t_midreset();
      wr(IDX_PERIPHERAL_CLOCK_ENABLE_LOW, 16'hf455);
      wr(IDX_PERIPHERAL_CLOCK_RATE, 16'h7000);
      wr(IDX_CLOCK_OUTPUT_SELECT, 16'h03c0);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
   endtask
////////////////////////////////////////
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_port_a();
      t_clock_out();
      t_reserved();
      t_rate();
      t_gate();
      t_midreset();
      conclude();
   end
endmodule // tb_top

// File: verilog/pcg_clock_control.sv
// Peripheral clock gating, clock rate select and test clock output
`timescale 1ns/10ps
module pcg_clock_control (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [pcg_pkg::BUS_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [pcg_pkg::BUS_W-1:0] hwdata,
   input wire logic hready,
   output logic [pcg_pkg::BUS_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Clock sources
   input wire logic sysClock,
   input wire logic periphClock,
   input wire logic sysClock2x,
   input wire logic sysClock3x,
   input wire logic relaxOscClock,
   input wire logic pllActive,
   // Port A peripheral outputs
   input wire logic [pcg_pkg::PA_BITS-1:0] pwmOut,
   output logic [pcg_pkg::PA_BITS-1:0] portAPeriphOut,
   // Port B bit 4 clock output pin
   input wire logic portBPinSelectClockOut,
   output logic clockOutPin,
   output logic clockOutPinEnable,
   // Peripheral clock rates
   output logic timerFastClock,
   output logic pulseWidthFastClock,
   output logic twoWireFastClock,
   // Peripheral clock gating
   input wire logic stopMode,
   input wire logic [pcg_pkg::REG_W-1:0] stopKeepClock,
   output logic [pcg_pkg::REG_W-1:0] periphClockRun,
   output logic [pcg_pkg::REG_W-1:0] periphStopped,
   // Peripheral bus access gating
   input wire logic [pcg_pkg::REG_W-1:0] periphAccessReq,
   output logic [pcg_pkg::REG_W-1:0] periphAccessGrant
);
   import pcg_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (REG_W > BUS_W) begin : g_reg_width
      $error("Register wider than the data bus");
   end
   if (ADDR_LSB + IDX_W > BUS_W) begin : g_index_width
      $error("Register index outside the address");
   end
   if (SRC_MSB + 1 != SRC_W || CLK_DIS_BIT != SRC_W) begin : g_src_field
      $error("Clock output source field misplaced");
   end
   if (PA_SEL_LSB != CLK_DIS_BIT + 1 || PA3_SEL_BIT != PA_SEL_LSB + PA_BITS - 1) begin : g_pa
      $error("Port A select field misplaced");
   end
   if (EN_CMP_B >= REG_W || TIMER_RATE_BIT >= REG_W) begin : g_bit_range
      $error("Control bit beyond the register width");
   end

   ////////////////////////////////////////////////////////////////////
   // Registers and bus state

   logic [REG_W-1:0] clockOutputSelect;
   logic [REG_W-1:0] peripheralClockRate;
   logic [REG_W-1:0] peripheralClockEnableLow;
   logic wrPending;
   logic [IDX_W-1:0] wrIndex;
   logic addrPhase;
   logic [REG_W-1:0] next_rdata;
   logic [SRC_W-1:0] clockOutSource;
   logic clockOutMux;

   function automatic logic [REG_W-1:0] readReg(input logic [IDX_W-1:0] idx,
         input logic [REG_W-1:0] sel, input logic [REG_W-1:0] rate,
         input logic [REG_W-1:0] en);
      logic [REG_W-1:0] val;
      val = '0;
      unique case (idx)
         IDX_CLOCK_OUTPUT_SELECT: val = sel & CLKSEL_MASK;
         IDX_PERIPHERAL_CLOCK_RATE: val = rate & RATE_MASK;
         IDX_PERIPHERAL_CLOCK_ENABLE_LOW: val = en & ENABLE_MASK;
         default: val = '0;
      endcase
      return val;
   endfunction

   function automatic logic [IDX_W-1:0] regIndex(input logic [BUS_W-1:0] addr);
      return addr[ADDR_LSB+IDX_W-1:ADDR_LSB];
   endfunction

   function automatic logic [REG_W-1:0] gateClocks(input logic [REG_W-1:0] en,
         input logic stop, input logic [REG_W-1:0] keep);
      return en & ({REG_W{!stop}} | keep);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // AHB-Lite slave

   assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wrPending <= 1'b0;
         wrIndex <= '0;
      end else begin
         wrPending <= addrPhase && hwrite;
         wrIndex <= regIndex(haddr);
      end
   end

   always_comb begin
      next_rdata = readReg(regIndex(haddr), clockOutputSelect,
         peripheralClockRate, peripheralClockEnableLow);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hrdata <= '0;
      end else if (addrPhase && !hwrite) begin
         hrdata <= {{(BUS_W-REG_W){1'b0}}, next_rdata};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register writes

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clockOutputSelect <= CLKSEL_RST;
      end else if (wrPending && wrIndex == IDX_CLOCK_OUTPUT_SELECT) begin
         clockOutputSelect <= hwdata[REG_W-1:0] & CLKSEL_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         peripheralClockRate <= RATE_RST;
      end else if (wrPending && wrIndex == IDX_PERIPHERAL_CLOCK_RATE) begin
         peripheralClockRate <= hwdata[REG_W-1:0] & RATE_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         peripheralClockEnableLow <= ENABLE_RST;
      end else if (wrPending && wrIndex == IDX_PERIPHERAL_CLOCK_ENABLE_LOW) begin
         peripheralClockEnableLow <= hwdata[REG_W-1:0] & ENABLE_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Port A peripheral output routing

   always_comb begin
      portAPeriphOut[3] = clockOutputSelect[PA3_SEL_BIT] ? relaxOscClock : pwmOut[3];
      portAPeriphOut[2] = clockOutputSelect[PA2_SEL_BIT] ? sysClock : pwmOut[2];
      portAPeriphOut[1] = clockOutputSelect[PA1_SEL_BIT] ? sysClock2x : pwmOut[1];
      portAPeriphOut[0] = clockOutputSelect[PA0_SEL_BIT] ? sysClock3x : pwmOut[0];
   end

   ////////////////////////////////////////////////////////////////////
   // Test clock output; plain mux, glitches on switching are accepted

   assign clockOutSource = clockOutputSelect[SRC_MSB:0];

   always_comb begin
      unique case (clockOutSource)
         SRC_SYSTEM: clockOutMux = sysClock;
         SRC_PERIPH: clockOutMux = periphClock;
         SRC_SYSTEM_3X: clockOutMux = sysClock3x && pllActive;
         default: clockOutMux = 1'b0;
      endcase
   end

   assign clockOutPinEnable = portBPinSelectClockOut && !clockOutputSelect[CLK_DIS_BIT];
   assign clockOutPin = clockOutPinEnable ? clockOutMux : 1'b0;

   ////////////////////////////////////////////////////////////////////
   // Peripheral clock rates

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         timerFastClock <= 1'b0;
         pulseWidthFastClock <= 1'b0;
         twoWireFastClock <= 1'b0;
      end else begin
         timerFastClock <= peripheralClockRate[TIMER_RATE_BIT] && pllActive;
         pulseWidthFastClock <= peripheralClockRate[PWM_RATE_BIT] && pllActive;
         twoWireFastClock <= peripheralClockRate[TWO_WIRE_RATE_BIT] && pllActive;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Peripheral clock gating

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         periphClockRun <= '0;
         periphStopped <= ENABLE_MASK;
      end else begin
         periphClockRun <= gateClocks(peripheralClockEnableLow, stopMode, stopKeepClock);
         periphStopped <= ENABLE_MASK & ~gateClocks(peripheralClockEnableLow, stopMode,
            stopKeepClock);
      end
   end

   assign periphAccessGrant = periphAccessReq & periphClockRun;

   ////////////////////////////////////////////////////////////////////
   // Assertions

   a_reset_select: assert property (
      @(posedge ref_clk) rst |=>
         clockOutputSelect == CLKSEL_RST && peripheralClockRate == RATE_RST
         && peripheralClockEnableLow == ENABLE_RST)
      else $error("Registers not at reset values after reset");

   a_porta_default: assert property (
      @(posedge ref_clk) disable iff (rst) $past(rst) |-> portAPeriphOut == pwmOut)
      else $error("Port A not on pulse-width outputs after reset");

   a_porta_relax: assert property (
      @(posedge ref_clk) disable iff (rst)
         clockOutputSelect[PA3_SEL_BIT] |-> portAPeriphOut[3] == relaxOscClock)
      else $error("Port A bit 3 not on relaxation clock");

   a_porta_sys: assert property (
      @(posedge ref_clk) disable iff (rst)
         !clockOutputSelect[PA2_SEL_BIT] |-> portAPeriphOut[2] == pwmOut[2])
      else $error("Port A bit 2 not on pulse-width output");

   a_porta_double: assert property (
      @(posedge ref_clk) disable iff (rst)
         clockOutputSelect[PA1_SEL_BIT] |-> portAPeriphOut[1] == sysClock2x)
      else $error("Port A bit 1 not on doubled clock");

   a_porta_triple: assert property (
      @(posedge ref_clk) disable iff (rst)
         clockOutputSelect[PA0_SEL_BIT] |-> portAPeriphOut[0] == sysClock3x)
      else $error("Port A bit 0 not on tripled clock");

   a_clkout_off: assert property (
      @(posedge ref_clk) disable iff (rst)
         clockOutputSelect[CLK_DIS_BIT] |-> !clockOutPinEnable && !clockOutPin)
      else $error("Clock output active while disabled");

   a_clkout_source: assert property (
      @(posedge ref_clk) disable iff (rst)
         clockOutPinEnable && clockOutSource == SRC_PERIPH |-> clockOutPin == periphClock)
      else $error("Clock output not on peripheral clock");

   a_clkout_pinsel: assert property (
      @(posedge ref_clk) disable iff (rst) !portBPinSelectClockOut |-> !clockOutPinEnable)
      else $error("Clock output driven without pin select");

   a_rate_pll: assert property (
      @(posedge ref_clk) disable iff (rst) !pllActive |=> !timerFastClock
         && !pulseWidthFastClock && !twoWireFastClock)
      else $error("Tripled rate chosen without PLL");

   a_rate_timer: assert property (
      @(posedge ref_clk) disable iff (rst)
         peripheralClockRate[TIMER_RATE_BIT] && pllActive |=> timerFastClock)
      else $error("Timer fast rate not applied");

   a_enable_write: assert property (
      @(posedge ref_clk) disable iff (rst)
         addrPhase && hwrite && haddr[ADDR_LSB+IDX_W-1:ADDR_LSB] ==
         IDX_PERIPHERAL_CLOCK_ENABLE_LOW ##1 1'b1 |=> ##1
         periphClockRun == (($past(hwdata[REG_W-1:0], 2) & ENABLE_MASK)
         & ({REG_W{!$past(stopMode)}} | $past(stopKeepClock))))
      else $error("Enable write did not reach clock gates");

   a_stop_gate: assert property (
      @(posedge ref_clk) disable iff (rst)
         stopMode |=> (periphClockRun & ~$past(stopKeepClock)) == '0)
      else $error("Clock runs in Stop without stop-keep");

   a_stopped_held: assert property (
      @(posedge ref_clk) disable iff (rst)
         (periphStopped & periphClockRun) == '0 && (periphStopped | periphClockRun)
         == ENABLE_MASK)
      else $error("Stopped flag disagrees with clock run");

   a_access_block: assert property (
      @(posedge ref_clk) disable iff (rst) (periphAccessGrant & ~periphClockRun) == '0)
      else $error("Access granted to gated peripheral");

   a_reserved_zero: assert property (
      @(posedge ref_clk) disable iff (rst) $past(addrPhase && !hwrite) && !$past(rst)
         |-> hrdata[BUS_W-1:REG_W] == '0)
      else $error("Reserved read bits not zero");

   a_porta_sysclk: assert property (
      @(posedge ref_clk) disable iff (rst)
         clockOutputSelect[PA2_SEL_BIT] |-> portAPeriphOut[2] == sysClock)
      else $error("Port A bit 2 not on system clock");

   a_clkout_system: assert property (
      @(posedge ref_clk) disable iff (rst)
         clockOutPinEnable && clockOutSource == SRC_SYSTEM |-> clockOutPin == sysClock)
      else $error("Clock output not on system clock");

   a_clkout_triple: assert property (
      @(posedge ref_clk) disable iff (rst) clockOutPinEnable
         && clockOutSource == SRC_SYSTEM_3X |-> clockOutPin == (sysClock3x && pllActive))
      else $error("Clock output not on tripled clock");

   a_clkout_reserved: assert property (
      @(posedge ref_clk) disable iff (rst) clockOutSource > SRC_SYSTEM_3X |-> !clockOutPin)
      else $error("Reserved source code drives the clock output");

   a_rate_pwm: assert property (
      @(posedge ref_clk) disable iff (rst)
         peripheralClockRate[PWM_RATE_BIT] && pllActive |=> pulseWidthFastClock)
      else $error("Pulse-width fast rate not applied");

   a_rate_twowire: assert property (
      @(posedge ref_clk) disable iff (rst)
         peripheralClockRate[TWO_WIRE_RATE_BIT] && pllActive |=> twoWireFastClock)
      else $error("Two-wire fast rate not applied");

   a_rate_slow: assert property (
      @(posedge ref_clk) disable iff (rst)
         !peripheralClockRate[TIMER_RATE_BIT] |=> !timerFastClock)
      else $error("Timer fast rate without its rate bit");

   a_stop_keep: assert property (
      @(posedge ref_clk) disable iff (rst) stopMode && stopKeepClock[EN_PWM]
         && peripheralClockEnableLow[EN_PWM] |=> periphClockRun[EN_PWM])
      else $error("Stop-keep clock not kept running");

   a_run_enabled: assert property (
      @(posedge ref_clk) disable iff (rst)
         (periphClockRun & ~$past(peripheralClockEnableLow)) == '0)
      else $error("Clock runs without its enable bit");

   c_stop_keep: cover property (
      @(posedge ref_clk) disable iff (rst) stopMode ##1 (periphClockRun != '0));
   c_clkout_on: cover property (
      @(posedge ref_clk) disable iff (rst) clockOutPinEnable);
   c_timer_fast: cover property (
      @(posedge ref_clk) disable iff (rst) timerFastClock);
   c_porta_clock: cover property (
      @(posedge ref_clk) disable iff (rst) clockOutputSelect[PA3_SEL_BIT:PA_SEL_LSB] != '0);
   c_clkout_reserved: cover property (
      @(posedge ref_clk) disable iff (rst) clockOutPinEnable && clockOutSource > SRC_SYSTEM_3X);

endmodule // pcg_clock_control

// File: verilog/pcg_pkg.sv
// Constants for the peripheral clock gate and clock output block
package pcg_pkg;
   // Register indices; byte address is four times the index
   localparam int IDX_W = 6;
   localparam logic [IDX_W-1:0] IDX_CLOCK_OUTPUT_SELECT = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_PERIPHERAL_CLOCK_RATE = 6'h0b;
   localparam logic [IDX_W-1:0] IDX_PERIPHERAL_CLOCK_ENABLE_LOW = 6'h0c;
   localparam int ADDR_LSB = 2;
   localparam int REG_W = 16;
   localparam int BUS_W = 32;

   // Clock output select fields
   localparam int PA3_SEL_BIT = 9;
   localparam int PA2_SEL_BIT = 8;
   localparam int PA1_SEL_BIT = 7;
   localparam int PA0_SEL_BIT = 6;
   localparam int PA_SEL_LSB = 6;
   localparam int PA_BITS = 4;
   localparam int CLK_DIS_BIT = 5;
   localparam int SRC_MSB = 4;
   localparam int SRC_W = 5;
   localparam logic [SRC_W-1:0] SRC_SYSTEM = 5'h00;
   localparam logic [SRC_W-1:0] SRC_PERIPH = 5'h01;
   localparam logic [SRC_W-1:0] SRC_SYSTEM_3X = 5'h02;

   // Clock rate fields
   localparam int TIMER_RATE_BIT = 14;
   localparam int PWM_RATE_BIT = 13;
   localparam int TWO_WIRE_RATE_BIT = 12;

   // Clock enable fields
   localparam int EN_CMP_B = 15;
   localparam int EN_CMP_A = 14;
   localparam int EN_CONVERTER_OUT1_CLOCK_ENABLE = 13;
   localparam int EN_CONVERTER_OUT0_CLOCK_ENABLE = 12;
   localparam int EN_ADC = 10;
   localparam int EN_TWO_WIRE = 6;
   localparam int EN_SERIAL = 4;
   localparam int EN_SPI = 2;
   localparam int EN_PWM = 0;

   // Writable masks and reset values
   localparam logic [REG_W-1:0] CLKSEL_MASK = 16'h03ff;
   localparam logic [REG_W-1:0] RATE_MASK = 16'h7000;
   localparam logic [REG_W-1:0] ENABLE_MASK = 16'hf455;
   localparam logic [REG_W-1:0] CLKSEL_RST = 16'h0020;
   localparam logic [REG_W-1:0] RATE_RST = 16'h0000;
   localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;

   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'h0;
endpackage
